// ---- include/bsq_map.svh ----
// register map, timing and field constants of the brake sequencer
`ifndef BSQ_MAP_SVH
`define BSQ_MAP_SVH
`define BSQ_A_CTRL 4'h0
`define BSQ_A_SETTLE 4'h1
`define BSQ_A_ACCEL 4'h2
`define BSQ_A_STOP 4'h3
`define BSQ_A_CONF 4'h4
`define BSQ_A_RELF 4'h5
`define BSQ_A_CURMIN 4'h6
`define BSQ_A_CLOSEF 4'h7
`define BSQ_A_TARGET 4'h8
`define BSQ_A_STAT 4'h9
`define BSQ_A_IRQ 4'hA
`define BSQ_A_MASK 4'hB
`define BSQ_A_FREQ 4'hC
`define BSQ_A_RATED 4'hD
`define BSQ_EN_ON 2'h1
`define BSQ_EN_OFF 2'h0
`define BSQ_CONF_FUNC 8'h2C
`define BSQ_REL_FUNC 8'h13
`define BSQ_FLT_FUNC 8'h14
`define BSQ_WAIT_MAX 16'h01F4
`define BSQ_FREQ_MAX 16'h9C40
`define BSQ_FAULT_CODE 8'h24
`define BSQ_RATED_RST 16'h0064
`define BSQ_TICK_US 10000
`define BSQ_CLK_MHZ 25
`define BSQ_B_CTRL_EN 1:0
`define BSQ_B_CTRL_LARGE 2
`define BSQ_B_CTRL_CLR 3
`define BSQ_I_FAULT 0
`define BSQ_I_REL 1
`define BSQ_I_DONE 2
`endif

// ---- include/bsq_pkg.sv ----
// types of the brake sequencer
package bsq_pkg;
  typedef enum logic [3:0] {
    BSQ_IDLE, BSQ_TO_REL, BSQ_SETTLE, BSQ_CONFIRM_ON, BSQ_ACCEL_WAIT,
    BSQ_RUN, BSQ_TO_CLOSE, BSQ_CONFIRM_OFF, BSQ_STOP_WAIT, BSQ_TO_ZERO,
    BSQ_TRIP, BSQ_PLAIN
  } bsq_state_t;
endpackage

// ---- hdl/bsq_brake_sequencer.sv ----
// brake sequencer core with avalon-mm register slave
`include "bsq_map.svh"
`default_nettype none
module bsq_brake_sequencer #(
  parameter int TICK_CYCLES = (`BSQ_TICK_US * `BSQ_CLK_MHZ),
  parameter int NUM_IN = 8,
  parameter int NUM_OUT = 5
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic run_cmd,
  input wire logic [15:0] out_current,
  input wire logic [NUM_IN-1:0] input_terminal_state,
  input wire logic [NUM_IN*8-1:0] input_terminal_assign,
  input wire logic [NUM_OUT*8-1:0] output_terminal_assign,
  output logic [15:0] freq_out,
  output logic [NUM_OUT-1:0] output_terminal_state,
  output logic brake_release_out,
  output logic brake_fault_out,
  output logic [7:0] fault_code,
  output logic irq
);
  import bsq_pkg::*;

  // ******************************
  // configuration registers
  // ******************************
  logic [1:0] brake_ctrl_enable_ff;
  logic size_large_ff;
  logic [15:0] release_settle_wait_ff;
  logic [15:0] accel_resume_wait_ff;
  logic [15:0] stop_resume_wait_ff;
  logic [15:0] confirm_wait_ff;
  logic [15:0] release_freq_ff;
  logic [15:0] release_current_min_ff;
  logic [15:0] close_freq_ff;
  logic [15:0] target_freq_ff;
  logic [15:0] rated_current_ff;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic [31:0] avs_readdata_ff;
  logic rd_done_ff;
  logic wr_ok;
  logic clr_fault;
  logic [2:0] ev;
  logic [16:0] cur_max;

  assign wr_ok = avs_write;
  assign clr_fault = wr_ok && avs_address == `BSQ_A_CTRL
    && avs_writedata[`BSQ_B_CTRL_CLR];

  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lim);
    clamp16 = (v > lim) ? lim : v;
  endfunction

  // threshold ceiling: 2.00 or 1.80 times rated
  always_comb begin
    if (size_large_ff) begin
      cur_max = 17'((rated_current_ff * 18) / 10);
    end else begin
      cur_max = {rated_current_ff, 1'b0};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      brake_ctrl_enable_ff <= `BSQ_EN_OFF;
      size_large_ff <= 1'b0;
      release_settle_wait_ff <= 16'h0000;
      accel_resume_wait_ff <= 16'h0000;
      stop_resume_wait_ff <= 16'h0000;
      confirm_wait_ff <= 16'h0000;
      release_freq_ff <= 16'h0000;
      close_freq_ff <= 16'h0000;
      target_freq_ff <= 16'h0000;
      rated_current_ff <= `BSQ_RATED_RST;
      release_current_min_ff <= `BSQ_RATED_RST;
      irq_mask_ff <= 3'h0;
    end else if (wr_ok) begin
      if (avs_address == `BSQ_A_CTRL) begin
        brake_ctrl_enable_ff <= avs_writedata[`BSQ_B_CTRL_EN];
        size_large_ff <= avs_writedata[`BSQ_B_CTRL_LARGE];
      end else if (avs_address == `BSQ_A_SETTLE) begin
        release_settle_wait_ff <= clamp16(avs_writedata[15:0],
          `BSQ_WAIT_MAX);
      end else if (avs_address == `BSQ_A_ACCEL) begin
        accel_resume_wait_ff <= clamp16(avs_writedata[15:0],
          `BSQ_WAIT_MAX);
      end else if (avs_address == `BSQ_A_STOP) begin
        stop_resume_wait_ff <= clamp16(avs_writedata[15:0],
          `BSQ_WAIT_MAX);
      end else if (avs_address == `BSQ_A_CONF) begin
        confirm_wait_ff <= clamp16(avs_writedata[15:0],
          `BSQ_WAIT_MAX);
      end else if (avs_address == `BSQ_A_RELF) begin
        release_freq_ff <= clamp16(avs_writedata[15:0],
          `BSQ_FREQ_MAX);
      end else if (avs_address == `BSQ_A_CURMIN) begin
        release_current_min_ff <= (17'(avs_writedata[15:0]) > cur_max)
          ? cur_max[15:0] : avs_writedata[15:0];
      end else if (avs_address == `BSQ_A_CLOSEF) begin
        close_freq_ff <= clamp16(avs_writedata[15:0],
          `BSQ_FREQ_MAX);
      end else if (avs_address == `BSQ_A_TARGET) begin
        target_freq_ff <= clamp16(avs_writedata[15:0], `BSQ_FREQ_MAX);
      end else if (avs_address == `BSQ_A_MASK) begin
        irq_mask_ff <= avs_writedata[2:0];
      end else if (avs_address == `BSQ_A_RATED) begin
        rated_current_ff <= avs_writedata[15:0];
        release_current_min_ff <= avs_writedata[15:0];
      end
    end
  end

  // ******************************
  // time base: 0.01 s tick
  // ******************************
  logic [$clog2(TICK_CYCLES)-1:0] div_ff;
  logic tick;
  assign tick = (div_ff == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
  always_ff @(posedge sys_clk) begin
    if (rst || tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  // ******************************
  // terminal allocation
  // ******************************
  logic confirm_used;
  logic brake_confirm_in;
  always_comb begin
    confirm_used = 1'b0;
    brake_confirm_in = 1'b0;
    // last assigned terminal wins
    for (int i = 0; i < NUM_IN; i++) begin
      if (input_terminal_assign[i*8 +: 8] == `BSQ_CONF_FUNC) begin
        confirm_used = 1'b1;
        brake_confirm_in = input_terminal_state[i];
      end
    end
  end

  // ******************************
  // sequencer
  // ******************************
  bsq_state_t state_ff;
  bsq_state_t nxt_state;
  logic [15:0] wait_ff;
  logic [15:0] freq_ff;
  logic [15:0] ramp_goal;
  logic ramp_hold;
  logic at_goal;
  logic rel_ff;
  logic flt_ff;
  logic [7:0] code_ff;
  logic wait_done;
  logic enabled;

  assign enabled = brake_ctrl_enable_ff == `BSQ_EN_ON;
  assign wait_done = (wait_ff == 16'h0000);
  assign at_goal = (freq_ff == ramp_goal);

  always_comb begin
    ramp_goal = freq_ff;
    ramp_hold = 1'b1;
    case (state_ff)
      BSQ_TO_REL: begin
        ramp_goal = release_freq_ff;
        ramp_hold = 1'b0;
      end
      BSQ_RUN, BSQ_PLAIN: begin
        ramp_goal = run_cmd ? target_freq_ff : 16'h0000;
        ramp_hold = 1'b0;
      end
      BSQ_TO_CLOSE: begin
        ramp_goal = release_freq_ff;
        ramp_hold = 1'b0;
      end
      BSQ_TO_ZERO: begin
        ramp_goal = 16'h0000;
        ramp_hold = 1'b0;
      end
      default: begin
        ramp_goal = freq_ff;
        ramp_hold = 1'b1;
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      BSQ_IDLE: begin
        if (run_cmd && enabled) begin
          nxt_state = BSQ_TO_REL;
        end else if (run_cmd) begin
          nxt_state = BSQ_PLAIN;
        end
      end
      BSQ_PLAIN: begin
        if (!run_cmd && freq_ff == 16'h0000) begin
          nxt_state = BSQ_IDLE;
        end
      end
      BSQ_TO_REL: begin
        if (at_goal) begin
          nxt_state = BSQ_SETTLE;
        end
      end
      BSQ_SETTLE: begin
        if (wait_done) begin
          if (out_current < release_current_min_ff) begin
            nxt_state = BSQ_TRIP;
          end else if (confirm_used) begin
            nxt_state = BSQ_CONFIRM_ON;
          end else begin
            nxt_state = BSQ_ACCEL_WAIT;
          end
        end
      end
      BSQ_CONFIRM_ON: begin
        if (brake_confirm_in) begin
          nxt_state = BSQ_ACCEL_WAIT;
        end else if (wait_done) begin
          nxt_state = BSQ_TRIP;
        end
      end
      BSQ_ACCEL_WAIT: begin
        if (confirm_used && !brake_confirm_in) begin
          nxt_state = BSQ_TRIP;
        end else if (wait_done) begin
          nxt_state = BSQ_RUN;
        end
      end
      BSQ_RUN: begin
        if (confirm_used && !brake_confirm_in) begin
          nxt_state = BSQ_TRIP;
        end else if (!run_cmd) begin
          nxt_state = BSQ_TO_CLOSE;
        end
      end
      BSQ_TO_CLOSE: begin
        if (confirm_used && !brake_confirm_in) begin
          nxt_state = BSQ_TRIP;
        end else if (at_goal) begin
          nxt_state = confirm_used ? BSQ_CONFIRM_OFF : BSQ_STOP_WAIT;
        end
      end
      BSQ_CONFIRM_OFF: begin
        if (!brake_confirm_in) begin
          nxt_state = BSQ_STOP_WAIT;
        end else if (wait_done) begin
          nxt_state = BSQ_TRIP;
        end
      end
      BSQ_STOP_WAIT: begin
        if (wait_done) begin
          nxt_state = BSQ_TO_ZERO;
        end
      end
      BSQ_TO_ZERO: begin
        if (at_goal) begin
          nxt_state = BSQ_IDLE;
        end
      end
      BSQ_TRIP: begin
        if (clr_fault && !run_cmd) begin
          nxt_state = BSQ_IDLE;
        end
      end
      default: begin
        nxt_state = BSQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= BSQ_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // wait timer loads on each state entry
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wait_ff <= 16'h0000;
    end else if (nxt_state != state_ff) begin
      case (nxt_state)
        BSQ_SETTLE: wait_ff <= release_settle_wait_ff;
        BSQ_CONFIRM_ON: wait_ff <= confirm_wait_ff;
        BSQ_ACCEL_WAIT: wait_ff <= accel_resume_wait_ff;
        BSQ_CONFIRM_OFF: wait_ff <= confirm_wait_ff;
        BSQ_STOP_WAIT: wait_ff <= stop_resume_wait_ff;
        default: wait_ff <= 16'h0000;
      endcase
    end else if (tick && !wait_done) begin
      wait_ff <= wait_ff - 1'b1;
    end
  end

  // ramp: 0.01 hz per tick step
  always_ff @(posedge sys_clk) begin
    if (rst || state_ff == BSQ_TRIP) begin
      freq_ff <= 16'h0000;
    end else if (tick && !ramp_hold && !at_goal) begin
      freq_ff <= (freq_ff < ramp_goal) ? freq_ff + 1'b1 : freq_ff - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !enabled) begin
      rel_ff <= 1'b0;
    end else if (nxt_state == BSQ_CONFIRM_ON
                 || nxt_state == BSQ_ACCEL_WAIT
                 || nxt_state == BSQ_RUN) begin
      rel_ff <= 1'b1;
    end else begin
      rel_ff <= (nxt_state == BSQ_TO_CLOSE);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flt_ff <= 1'b0;
      code_ff <= 8'h00;
    end else if (nxt_state == BSQ_TRIP && state_ff != BSQ_TRIP) begin
      flt_ff <= 1'b1;
      code_ff <= `BSQ_FAULT_CODE;
    end else if (nxt_state != BSQ_TRIP) begin
      flt_ff <= 1'b0;
      code_ff <= 8'h00;
    end
  end

  // output terminal mapping
  always_comb begin
    for (int j = 0; j < NUM_OUT; j++) begin
      if (output_terminal_assign[j*8 +: 8] == `BSQ_REL_FUNC) begin
        output_terminal_state[j] = rel_ff;
      end else if (output_terminal_assign[j*8 +: 8] == `BSQ_FLT_FUNC) begin
        output_terminal_state[j] = flt_ff;
      end else begin
        output_terminal_state[j] = 1'b0;
      end
    end
  end

  assign freq_out = freq_ff;
  assign brake_release_out = rel_ff;
  assign brake_fault_out = flt_ff;
  assign fault_code = code_ff;

  // ******************************
  // interrupts and read path
  // ******************************
  logic rel_prev_ff;
  assign ev[`BSQ_I_FAULT] = nxt_state == BSQ_TRIP && state_ff != BSQ_TRIP;
  assign ev[`BSQ_I_REL] = rel_ff != rel_prev_ff;
  assign ev[`BSQ_I_DONE] = state_ff == BSQ_TO_ZERO && nxt_state == BSQ_IDLE;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rel_prev_ff <= 1'b0;
    end else begin
      rel_prev_ff <= rel_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_stat_ff <= 3'h0;
    end else if (wr_ok && avs_address == `BSQ_A_IRQ) begin
      irq_stat_ff <= (irq_stat_ff & ~avs_writedata[2:0]) | ev;
    end else begin
      irq_stat_ff <= irq_stat_ff | ev;
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata_ff <= 32'h0000_0000;
      rd_done_ff <= 1'b0;
    end else begin
      rd_done_ff <= avs_read && !rd_done_ff;
      if (avs_address == `BSQ_A_CTRL) begin
        avs_readdata_ff <= {29'h0, size_large_ff, brake_ctrl_enable_ff};
      end else if (avs_address == `BSQ_A_SETTLE) begin
        avs_readdata_ff <= {16'h0, release_settle_wait_ff};
      end else if (avs_address == `BSQ_A_ACCEL) begin
        avs_readdata_ff <= {16'h0, accel_resume_wait_ff};
      end else if (avs_address == `BSQ_A_STOP) begin
        avs_readdata_ff <= {16'h0, stop_resume_wait_ff};
      end else if (avs_address == `BSQ_A_CONF) begin
        avs_readdata_ff <= {16'h0, confirm_wait_ff};
      end else if (avs_address == `BSQ_A_RELF) begin
        avs_readdata_ff <= {16'h0, release_freq_ff};
      end else if (avs_address == `BSQ_A_CURMIN) begin
        avs_readdata_ff <= {16'h0, release_current_min_ff};
      end else if (avs_address == `BSQ_A_CLOSEF) begin
        avs_readdata_ff <= {16'h0, close_freq_ff};
      end else if (avs_address == `BSQ_A_TARGET) begin
        avs_readdata_ff <= {16'h0, target_freq_ff};
      end else if (avs_address == `BSQ_A_STAT) begin
        avs_readdata_ff <= {code_ff, 14'h0, confirm_used, flt_ff,
          rel_ff, 3'h0, 4'(state_ff)};
      end else if (avs_address == `BSQ_A_IRQ) begin
        avs_readdata_ff <= {29'h0, irq_stat_ff};
      end else if (avs_address == `BSQ_A_MASK) begin
        avs_readdata_ff <= {29'h0, irq_mask_ff};
      end else if (avs_address == `BSQ_A_FREQ) begin
        avs_readdata_ff <= {16'h0, freq_ff};
      end else if (avs_address == `BSQ_A_RATED) begin
        avs_readdata_ff <= {16'h0, rated_current_ff};
      end else begin
        avs_readdata_ff <= 32'h0000_0000;
      end
    end
  end
  assign avs_readdata = avs_readdata_ff;
  assign avs_waitrequest = avs_read && !rd_done_ff;
endmodule
`default_nettype wire

// ---- verif/bsq_brake_sequencer_chk.sv ----
// assertion checker for the brake sequencer ports
`default_nettype none
module bsq_brake_sequencer_chk #(
  parameter int NUM_OUT = 5
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic run_cmd,
  input wire logic [NUM_OUT*8-1:0] output_terminal_assign,
  input wire logic [NUM_OUT-1:0] output_terminal_state,
  input wire logic [15:0] freq_out,
  input wire logic brake_release_out,
  input wire logic brake_fault_out,
  input wire logic [7:0] fault_code
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ***************************************************
  // properties
  // ***************************************************
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_stopped;
    !brake_release_out && freq_out == 16'h0000;
  endsequence
  a_read_wait: assert property ($rose(avs_read) |-> s_one_wait)
    else $error("read wait state wrong");
  a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  a_fault_code: assert property (fault_code ==
    (brake_fault_out ? 8'h24 : 8'h00)) else $error("fault code wrong");
  a_trip_stops: assert property ($rose(brake_fault_out) |->
    ##[0:1] s_stopped) else $error("trip left output running");
  a_ramp_step: assert property (!brake_fault_out ##1 !brake_fault_out |->
    freq_out == $past(freq_out) || freq_out == $past(freq_out) + 16'h1 ||
    freq_out + 16'h1 == $past(freq_out)) else $error("ramp jumped");
  a_rel_on_hold: assert property ($rose(brake_release_out) |->
    $stable(freq_out)) else $error("frequency moved at release");
  a_rel_off_hold: assert property ($fell(brake_release_out) &&
    !brake_fault_out |-> $stable(freq_out))
    else $error("frequency moved at close");
  a_fault_clear: assert property ($fell(brake_fault_out) |->
    $past(avs_write) && $past(avs_address) == 4'h0 &&
    ($past(avs_writedata) & 32'h8) != 32'h0 && !$past(run_cmd))
    else $error("fault cleared without request");
  a_term_rel: assert property (output_terminal_assign[7:0] == 8'h13 |->
    output_terminal_state[0] == brake_release_out)
    else $error("release terminal wrong");
  a_term_flt: assert property (output_terminal_assign[15:8] == 8'h14 |->
    output_terminal_state[1] == brake_fault_out)
    else $error("fault terminal wrong");
endmodule
`default_nettype wire

// ---- verif/bsq_brake_model.sv ----
// external brake with a confirmation contact
`default_nettype none
module bsq_brake_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic release_in,
  input wire logic [1:0] fail_mode,
  output logic confirm_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] lag_ff;
  logic [2:0] hold_ff;
  // ***************************************************
  // mechanical delay and contact
  // ***************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) lag_ff <= 2'h0;
    else lag_ff <= {lag_ff[0], release_in};
  end
  // cycles since the contact closed
  always_ff @(posedge sys_clk) begin
    if (rst || !confirm_out) hold_ff <= 3'h0;
    else if (hold_ff != 3'h7) hold_ff <= hold_ff + 3'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) confirm_out <= 1'b0;
    else case (fail_mode)
      2'h1: confirm_out <= 1'b0;
      2'h2: confirm_out <= confirm_out | lag_ff[1];
      2'h3: confirm_out <= lag_ff[1] && hold_ff < 3'h5;
      default: confirm_out <= lag_ff[1];
    endcase
  end
endmodule
`default_nettype wire

// ---- verif/bsq_brake_sequencer_tb.sv ----
// self-checking testbench of the brake sequencer
`include "bsq_map.svh"
`default_nettype none
module bsq_brake_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ***************************************************
  // signals
  // ***************************************************
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, run_cmd;
  logic brake_release_out, brake_fault_out, irq, confirm, rel_seen;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [15:0] out_current, freq_out;
  logic [7:0] fault_code;
  logic [63:0] in_assign;
  logic [39:0] out_assign;
  logic [4:0] out_state;
  logic [1:0] fail_mode;
  logic [7:0] in_state;
  int n_fail, num_checks;
  assign in_state = {4'h0, confirm, 3'h0};
  bsq_brake_sequencer #(.TICK_CYCLES(4)) dut_u (.sys_clk(sys_clk),
    .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .run_cmd(run_cmd), .out_current(out_current),
    .input_terminal_state(in_state), .input_terminal_assign(in_assign),
    .output_terminal_assign(out_assign), .freq_out(freq_out),
    .output_terminal_state(out_state), .brake_release_out(brake_release_out),
    .brake_fault_out(brake_fault_out), .fault_code(fault_code), .irq(irq));
  bsq_brake_model brake_u (.sys_clk(sys_clk), .rst(rst),
    .release_in(out_state[0]), .fail_mode(fail_mode), .confirm_out(confirm));
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (brake_release_out) rel_seen <= 1'b1;
  // ***************************************************
  // tasks
  // ***************************************************
  task automatic print_verdict();
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge sys_clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  function automatic logic [15:0] pick(input int sel);
    if (sel == 0) return freq_out;
    if (sel == 1) return {15'h0, brake_release_out};
    return {15'h0, brake_fault_out};
  endfunction
  task automatic wait_sig(input int sel, input logic [15:0] v, output int n);
    n = 0;
    while (pick(sel) !== v && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) n_fail++;
  endtask
  task automatic drive_run(input logic v);
    @(posedge sys_clk);
    run_cmd <= v;
  endtask
  task automatic run_cycle(input logic used);
    int n;
    rd(`BSQ_A_STAT, {22'h0, used, 9'h0});
    drive_run(1'b1);
    wait_sig(0, 16'h2, n);
    wait_sig(1, 16'h1, n);
    chk(n >= 4, 1'b1);
    chk(freq_out, 16'h2);
    chk(out_state[0], 1'b1);
    chk(out_state[4:2], 3'h0);
    @(posedge sys_clk);
    chk(freq_out, 16'h2);
    wait_sig(0, 16'h4, n);
    chk(freq_out, 16'h4);
    drive_run(1'b0);
    wait_sig(1, 16'h0, n);
    chk(freq_out, 16'h2);
    wait_sig(0, 16'h1, n);
    chk(n >= 4, 1'b1);
    wait_sig(0, 16'h0, n);
    chk(brake_fault_out, 1'b0);
  endtask
  // ***************************************************
  // tests
  // ***************************************************
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    print_verdict();
  end
  initial begin
    int n;
    sys_clk = 1'b0;
    rst = 1'b1;
    {avs_read, avs_write, run_cmd, rel_seen} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    out_current = 16'h0080;
    in_assign = 64'h0;
    out_assign = 40'h0000001413;
    fail_mode = 2'h0;
    n_fail = 0;
    num_checks = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`BSQ_A_CTRL, 32'h0);
    for (int a = 1; a < 5; a++) begin
      rd(a[3:0], 32'h0);
      wr(a[3:0], 32'hFFFF);
      rd(a[3:0], 32'h1F4);
      wr(a[3:0], (a == 4) ? 32'h3 : ((a == 1) ? 32'h2 : 32'h1));
    end
    rd(`BSQ_A_RELF, 32'h0);
    rd(`BSQ_A_CLOSEF, 32'h0);
    wr(`BSQ_A_RELF, 32'hFFFF);
    rd(`BSQ_A_RELF, 32'h9C40);
    wr(`BSQ_A_CLOSEF, 32'hFFFF);
    rd(`BSQ_A_CLOSEF, 32'h9C40);
    rd(`BSQ_A_CURMIN, 32'h64);
    wr(`BSQ_A_CURMIN, 32'hFFFF);
    rd(`BSQ_A_CURMIN, 32'hC8);
    wr(`BSQ_A_CTRL, 32'h4);
    wr(`BSQ_A_CURMIN, 32'hFFFF);
    rd(`BSQ_A_CURMIN, 32'hB4);
    wr(`BSQ_A_CTRL, 32'h0);
    wr(`BSQ_A_CURMIN, 32'h64);
    rd(4'hE, 32'h0);
    wr(`BSQ_A_RELF, 32'h2);
    wr(`BSQ_A_TARGET, 32'h3);
    for (int c = 0; c < 3; c++) begin
      wr(`BSQ_A_CTRL, (c == 0) ? 32'h0 : c + 1);
      rel_seen = 1'b0;
      drive_run(1'b1);
      wait_sig(0, 16'h3, n);
      chk(freq_out, 16'h3);
      chk(rel_seen, 1'b0);
      drive_run(1'b0);
      wait_sig(0, 16'h0, n);
      chk(brake_fault_out, 1'b0);
    end
    wr(`BSQ_A_TARGET, 32'h4);
    wr(`BSQ_A_CTRL, 32'h1);
    run_cycle(1'b0);
    in_assign <= 64'h2C000000;
    run_cycle(1'b1);
    wr(`BSQ_A_MASK, 32'h1);
    for (int k = 0; k < 4; k++) begin
      fail_mode <= (k == 3) ? 2'h0 : 2'(k + 1);
      out_current <= (k == 3) ? 16'h0010 : 16'h0080;
      rel_seen = 1'b0;
      drive_run(1'b1);
      if (k == 1) begin
        wait_sig(0, 16'h4, n);
        drive_run(1'b0);
      end
      wait_sig(2, 16'h1, n);
      chk(fault_code, 8'h24);
      chk(out_state[1], 1'b1);
      if (k == 3) chk(rel_seen, 1'b0);
      chk(irq, 1'b1);
      wr(`BSQ_A_MASK, 32'h0);
      chk(irq, 1'b0);
      wr(`BSQ_A_MASK, 32'h1);
      drive_run(1'b0);
      wr(`BSQ_A_CTRL, 32'h9);
      wr(`BSQ_A_IRQ, 32'h7);
      chk(brake_fault_out, 1'b0);
      chk(irq, 1'b0);
    end
    print_verdict();
  end
endmodule
bind bsq_brake_sequencer bsq_brake_sequencer_chk #(.NUM_OUT(NUM_OUT)) chk_u (
  .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .run_cmd(run_cmd),
  .output_terminal_assign(output_terminal_assign),
  .output_terminal_state(output_terminal_state), .freq_out(freq_out),
  .brake_release_out(brake_release_out), .brake_fault_out(brake_fault_out),
  .fault_code(fault_code));
`default_nettype wire
